// ---- hw/rab_consts.svh ----
// Purpose: constants of the arithmetic, logic, multiply and program-flow executor
// Assumes: one core clock, decoded instructions arrive from the fetch stage
// Notes: cycle counts are totals per instruction, including the issue cycle
//
// Behaviour
// - add and add-with-carry write sum, update Z C N V H, one cycle.
// - word add immediate adds constant to pair, updates Z C N V S, two cycles.
// - word subtract immediate subtracts from pair, updates Z C N V S, two cycles.
// - subtract register or constant, optional borrow, updates Z C N V H, one cycle.
// - AND, OR, XOR write result, update only Z N V, one cycle.
// - ones complement writes all-ones minus value, updates Z C N V, one cycle.
// - clear bits ANDs destination with inverted mask, updates Z N V.
// - multiplies put 16-bit product in product pair, update Z C, two cycles.
// - fractional multiplies write product shifted left one, update Z C, two cycles.
// - relative jump and call load pc plus offset plus one; two or three cycles.
// - indirect jump and call load pc from pointer pair; two or three cycles.
// - direct jump and call load absolute address; three or four cycles.
// - compare skip equal skips next when registers equal, flags untouched.
// - compares update Z N V C H and write no register, one cycle.
// - register bit skips skip next on bit clear or set, one to three cycles.
// - io bit skips test an io register bit, skip on clear or set.
// - status branches add offset plus one when selected bit matches value.
// - signed ge taken when N xor V is zero, lt when one.
// - unsigned same-or-higher taken on carry clear, lower on carry set.
// - single flag branches test the flag and branch relative offset plus one.
`ifndef RAB_CONSTS_SVH
`define RAB_CONSTS_SVH

// status register bit positions
`define RAB_FLAG_C 3'h0
`define RAB_FLAG_Z 3'h1
`define RAB_FLAG_N 3'h2
`define RAB_FLAG_V 3'h3
`define RAB_FLAG_S 3'h4
`define RAB_FLAG_H 3'h5
`define RAB_FLAG_T 3'h6
`define RAB_FLAG_I 3'h7

// reset values
`define RAB_PC_RESET 16'h0000
`define RAB_STATUS_REGISTER_RESET 8'h00
`define RAB_GPR_RESET 8'h00

// fixed register indices
`define RAB_PROD_LO 5'h00
`define RAB_PTR_LO 5'h1e
`define RAB_PTR_HI 5'h1f

// cycle counts
`define RAB_CYC_ONE 3'h1
`define RAB_CYC_TWO 3'h2
`define RAB_CYC_THREE 3'h3
`define RAB_CYC_FOUR 3'h4

`endif

// ---- hw/rab_pkg.sv ----
// Purpose: types shared by the executor files
// Assumes: constants header on the include path
// Notes: immediate forms reuse register opcodes with use_imm set
`include "rab_consts.svh"

package rab_pkg;

	typedef enum logic [5:0]
	{
		op_nop, op_add, op_adc, op_sub, op_sbc, op_word_add_immediate,
		op_word_subtract_immediate, op_and, op_or, op_eor, op_ones_complement,
		op_clear_bits_mask, op_mul, op_muls, op_signed_by_unsigned_multiply,
		op_fractional_multiply, op_fmuls, op_fmulsu, op_relative_jump,
		op_relative_call, op_indirect_jump, op_indirect_call, op_jmp, op_call,
		op_compare_skip_equal, op_cp, op_cpc, op_skip_reg_bit_clear,
		op_skip_reg_bit_set, op_skip_io_bit_clear, op_skip_io_bit_set,
		op_branch_status_bit_set, op_branch_status_bit_clear,
		op_branch_signed_ge, op_branch_signed_lt
	} rab_op_type;

	typedef struct packed
	{
		logic valid;
		rab_op_type op;
		logic use_imm;
		logic [4:0] rd;
		logic [4:0] rr;
		logic [7:0] imm;
		logic [11:0] offset;
		logic [15:0] target;
		logic [2:0] bit_sel;
		logic [7:0] io_value;
		logic two_word;
		logic next_two_word;
	} rab_instr_type;

	typedef struct packed
	{
		logic valid;
		logic word;
		logic [4:0] addr;
		logic [15:0] data;
	} rab_wr_type;

	typedef struct packed
	{
		logic valid;
		logic [15:0] addr;
	} rab_push_type;

	typedef enum logic [1:0]
	{
		st_ready = 2'b01,
		st_busy = 2'b10
	} rab_state_type;

endpackage

// ---- hw/rab_addsub.sv ----
// Purpose: 8-bit add or subtract with carry, half carry and overflow
// Assumes: purely combinational, used by the executor
// Notes: c and h are borrows when sub is set
`timescale 1ns/1ps

module rab_addsub
(
	// operands
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic cin,
	input wire logic sub,
	// results
	output logic [7:0] res,
	output logic c,
	output logic h,
	output logic v
);

	logic [8:0] full;
	logic [4:0] low;

	always_comb
	begin
		if (sub)
		begin
			full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
			low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
			v = (a[7] & ~b[7] & ~full[7]) | (~a[7] & b[7] & full[7]);
		end
		else
		begin
			full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
			low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
			v = (a[7] & b[7] & ~full[7]) | (~a[7] & ~b[7] & full[7]);
		end
		res = full[7:0];
		c = full[8];
		h = low[4];
	end

endmodule

// ---- hw/rab_exec.sv ----
// Purpose: executes arithmetic, logic, multiply and program-flow instructions
// Assumes: instr is decoded on ref_clk; io_value is sampled by the decode stage
// Notes: all effects land at the issue edge; longer instructions then hold off issue
`timescale 1ns/1ps
`include "rab_consts.svh"

module rab_exec
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// decoded instruction
	input wire rab_pkg::rab_instr_type instr,
	output logic issue_ready,
	// architectural state
	output logic [15:0] pc,
	output logic [7:0] status_register,
	// register file write report
	output rab_pkg::rab_wr_type reg_wr,
	// return address push
	output rab_pkg::rab_push_type push
);

	////////////////////////////////////////////////////////////////////////
	// storage and declarations

	logic [7:0] gpr [32];
	rab_pkg::rab_state_type state;
	logic [2:0] wait_left;

	logic accept;
	logic [7:0] rd_val;
	logic [7:0] rr_val;
	logic [7:0] rr_reg;
	logic [15:0] pair_val;
	logic [15:0] ptr_val;
	logic [15:0] word_res;
	logic [4:0] rd_hi;
	logic [7:0] as_res;
	logic as_c;
	logic as_h;
	logic as_v;
	logic as_cin;
	logic as_sub;
	logic sign_a;
	logic sign_b;
	logic signed [17:0] prod;
	logic [15:0] prod16;
	logic [15:0] seq_pc;
	logic [15:0] rel_pc;
	logic [15:0] skip_pc;
	logic [2:0] skip_cyc;

	logic [15:0] next_pc;
	logic [7:0] next_status_register;
	logic [2:0] next_cycles;
	rab_pkg::rab_wr_type next_wr;
	rab_pkg::rab_push_type next_push;

	////////////////////////////////////////////////////////////////////////
	// operand fetch

	assign accept = instr.valid & issue_ready;
	assign rd_hi = instr.rd | 5'h01;
	assign rd_val = gpr[instr.rd];
	assign rr_reg = gpr[instr.rr];
	assign rr_val = instr.use_imm ? instr.imm : rr_reg;
	assign pair_val = {gpr[rd_hi], gpr[instr.rd]};
	assign ptr_val = {gpr[`RAB_PTR_HI], gpr[`RAB_PTR_LO]};

	assign seq_pc = instr.two_word ? pc + 16'h0002 : pc + 16'h0001;
	assign rel_pc = pc + {{4{instr.offset[11]}}, instr.offset} + 16'h0001;
	assign skip_pc = instr.next_two_word ? pc + 16'h0003 : pc + 16'h0002;
	assign skip_cyc = instr.next_two_word ? `RAB_CYC_THREE : `RAB_CYC_TWO;

	////////////////////////////////////////////////////////////////////////
	// add and subtract unit

	always_comb
	begin
		as_sub = 1'b1;
		as_cin = 1'b0;
		case (instr.op)
			rab_pkg::op_add:
			begin
				as_sub = 1'b0;
			end
			rab_pkg::op_adc:
			begin
				as_sub = 1'b0;
				as_cin = status_register[`RAB_FLAG_C];
			end
			rab_pkg::op_sbc, rab_pkg::op_cpc:
			begin
				as_cin = status_register[`RAB_FLAG_C];
			end
			default:
			begin
				as_sub = 1'b1;
			end
		endcase
	end

	rab_addsub u_addsub
	(
		.a(rd_val),
		.b(rr_val),
		.cin(as_cin),
		.sub(as_sub),
		.res(as_res),
		.c(as_c),
		.h(as_h),
		.v(as_v)
	);

	////////////////////////////////////////////////////////////////////////
	// multiplier and word arithmetic

	always_comb
	begin
		sign_a = 1'b0;
		sign_b = 1'b0;
		if (instr.op == rab_pkg::op_muls || instr.op == rab_pkg::op_fmuls)
		begin
			sign_a = 1'b1;
			sign_b = 1'b1;
		end
		else if (instr.op == rab_pkg::op_signed_by_unsigned_multiply ||
			instr.op == rab_pkg::op_fmulsu)
		begin
			sign_a = 1'b1;
		end
	end

	assign prod = $signed({sign_a & rd_val[7], rd_val}) * $signed({sign_b & rr_reg[7], rr_reg});
	assign prod16 = prod[15:0];

	assign word_res = (instr.op == rab_pkg::op_word_add_immediate) ?
		pair_val + {8'h00, instr.imm} : pair_val - {8'h00, instr.imm};

	////////////////////////////////////////////////////////////////////////
	// execute

	always_comb
	begin
		// unlisted flags keep their values
		next_status_register = status_register;
		next_pc = seq_pc;
		next_cycles = `RAB_CYC_ONE;
		next_wr = '0;
		next_push = '0;
		case (instr.op)
			rab_pkg::op_add, rab_pkg::op_adc, rab_pkg::op_sub, rab_pkg::op_sbc:
			begin
				next_wr.valid = 1'b1;
				next_wr.addr = instr.rd;
				next_wr.data = {8'h00, as_res};
				next_status_register[`RAB_FLAG_C] = as_c;
				next_status_register[`RAB_FLAG_H] = as_h;
				next_status_register[`RAB_FLAG_V] = as_v;
				next_status_register[`RAB_FLAG_N] = as_res[7];
				// with borrow, zero only stays set through a zero result
				if (instr.op == rab_pkg::op_sbc)
					next_status_register[`RAB_FLAG_Z] = (as_res == 8'h00) & status_register[`RAB_FLAG_Z];
				else
					next_status_register[`RAB_FLAG_Z] = (as_res == 8'h00);
			end
			rab_pkg::op_cp, rab_pkg::op_cpc:
			begin
				next_status_register[`RAB_FLAG_C] = as_c;
				next_status_register[`RAB_FLAG_H] = as_h;
				next_status_register[`RAB_FLAG_V] = as_v;
				next_status_register[`RAB_FLAG_N] = as_res[7];
				if (instr.op == rab_pkg::op_cpc)
					next_status_register[`RAB_FLAG_Z] = (as_res == 8'h00) & status_register[`RAB_FLAG_Z];
				else
					next_status_register[`RAB_FLAG_Z] = (as_res == 8'h00);
			end
			rab_pkg::op_word_add_immediate:
			begin
				next_cycles = `RAB_CYC_TWO;
				next_wr.valid = 1'b1;
				next_wr.word = 1'b1;
				next_wr.addr = instr.rd;
				next_wr.data = word_res;
				next_status_register[`RAB_FLAG_V] = ~pair_val[15] & word_res[15];
				next_status_register[`RAB_FLAG_C] = pair_val[15] & ~word_res[15];
				next_status_register[`RAB_FLAG_N] = word_res[15];
				next_status_register[`RAB_FLAG_Z] = (word_res == 16'h0000);
				next_status_register[`RAB_FLAG_S] = word_res[15] ^ (~pair_val[15] & word_res[15]);
			end
			rab_pkg::op_word_subtract_immediate:
			begin
				next_cycles = `RAB_CYC_TWO;
				next_wr.valid = 1'b1;
				next_wr.word = 1'b1;
				next_wr.addr = instr.rd;
				next_wr.data = word_res;
				next_status_register[`RAB_FLAG_V] = pair_val[15] & ~word_res[15];
				next_status_register[`RAB_FLAG_C] = ~pair_val[15] & word_res[15];
				next_status_register[`RAB_FLAG_N] = word_res[15];
				next_status_register[`RAB_FLAG_Z] = (word_res == 16'h0000);
				next_status_register[`RAB_FLAG_S] = word_res[15] ^ (pair_val[15] & ~word_res[15]);
			end
			rab_pkg::op_and, rab_pkg::op_or, rab_pkg::op_eor, rab_pkg::op_clear_bits_mask:
			begin
				next_wr.valid = 1'b1;
				next_wr.addr = instr.rd;
				if (instr.op == rab_pkg::op_and)
					next_wr.data = {8'h00, rd_val & rr_val};
				else if (instr.op == rab_pkg::op_or)
					next_wr.data = {8'h00, rd_val | rr_val};
				else if (instr.op == rab_pkg::op_eor)
					next_wr.data = {8'h00, rd_val ^ rr_val};
				else
					next_wr.data = {8'h00, rd_val & (8'hff - rr_val)};
				next_status_register[`RAB_FLAG_V] = 1'b0;
				next_status_register[`RAB_FLAG_N] = next_wr.data[7];
				next_status_register[`RAB_FLAG_Z] = (next_wr.data[7:0] == 8'h00);
			end
			rab_pkg::op_ones_complement:
			begin
				next_wr.valid = 1'b1;
				next_wr.addr = instr.rd;
				next_wr.data = {8'h00, 8'hff - rd_val};
				next_status_register[`RAB_FLAG_C] = 1'b1;
				next_status_register[`RAB_FLAG_V] = 1'b0;
				next_status_register[`RAB_FLAG_N] = next_wr.data[7];
				next_status_register[`RAB_FLAG_Z] = (next_wr.data[7:0] == 8'h00);
			end
			rab_pkg::op_mul, rab_pkg::op_muls, rab_pkg::op_signed_by_unsigned_multiply:
			begin
				next_cycles = `RAB_CYC_TWO;
				next_wr.valid = 1'b1;
				next_wr.word = 1'b1;
				next_wr.addr = `RAB_PROD_LO;
				next_wr.data = prod16;
				next_status_register[`RAB_FLAG_C] = prod16[15];
				next_status_register[`RAB_FLAG_Z] = (prod16 == 16'h0000);
			end
			rab_pkg::op_fractional_multiply, rab_pkg::op_fmuls, rab_pkg::op_fmulsu:
			begin
				// carry takes the top bit before the shift
				next_cycles = `RAB_CYC_TWO;
				next_wr.valid = 1'b1;
				next_wr.word = 1'b1;
				next_wr.addr = `RAB_PROD_LO;
				next_wr.data = {prod16[14:0], 1'b0};
				next_status_register[`RAB_FLAG_C] = prod16[15];
				next_status_register[`RAB_FLAG_Z] = ({prod16[14:0], 1'b0} == 16'h0000);
			end
			rab_pkg::op_relative_jump:
			begin
				next_pc = rel_pc;
				next_cycles = `RAB_CYC_TWO;
			end
			rab_pkg::op_relative_call:
			begin
				next_pc = rel_pc;
				next_cycles = `RAB_CYC_THREE;
				next_push.valid = 1'b1;
				next_push.addr = seq_pc;
			end
			rab_pkg::op_indirect_jump:
			begin
				next_pc = ptr_val;
				next_cycles = `RAB_CYC_TWO;
			end
			rab_pkg::op_indirect_call:
			begin
				next_pc = ptr_val;
				next_cycles = `RAB_CYC_THREE;
				next_push.valid = 1'b1;
				next_push.addr = seq_pc;
			end
			rab_pkg::op_jmp:
			begin
				next_pc = instr.target;
				next_cycles = `RAB_CYC_THREE;
			end
			rab_pkg::op_call:
			begin
				next_pc = instr.target;
				next_cycles = `RAB_CYC_FOUR;
				next_push.valid = 1'b1;
				next_push.addr = seq_pc;
			end
			rab_pkg::op_compare_skip_equal:
			begin
				if (rd_val == rr_reg)
				begin
					next_pc = skip_pc;
					next_cycles = skip_cyc;
				end
			end
			rab_pkg::op_skip_reg_bit_clear, rab_pkg::op_skip_reg_bit_set:
			begin
				if (rr_reg[instr.bit_sel] == (instr.op == rab_pkg::op_skip_reg_bit_set))
				begin
					next_pc = skip_pc;
					next_cycles = skip_cyc;
				end
			end
			rab_pkg::op_skip_io_bit_clear, rab_pkg::op_skip_io_bit_set:
			begin
				if (instr.io_value[instr.bit_sel] == (instr.op == rab_pkg::op_skip_io_bit_set))
				begin
					next_pc = skip_pc;
					next_cycles = skip_cyc;
				end
			end
			rab_pkg::op_branch_status_bit_set, rab_pkg::op_branch_status_bit_clear:
			begin
				// equal, carry, minus, half carry, t and overflow branches select a bit
				if (status_register[instr.bit_sel] ==
					(instr.op == rab_pkg::op_branch_status_bit_set))
				begin
					next_pc = rel_pc;
					next_cycles = `RAB_CYC_TWO;
				end
			end
			rab_pkg::op_branch_signed_ge, rab_pkg::op_branch_signed_lt:
			begin
				if ((status_register[`RAB_FLAG_N] ^ status_register[`RAB_FLAG_V]) ==
					(instr.op == rab_pkg::op_branch_signed_lt))
				begin
					next_pc = rel_pc;
					next_cycles = `RAB_CYC_TWO;
				end
			end
			default:
			begin
				next_cycles = `RAB_CYC_ONE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// issue control

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state <= rab_pkg::st_ready;
			wait_left <= 3'h0;
			issue_ready <= 1'b1;
		end
		else
		begin
			case (state)
				rab_pkg::st_ready:
				begin
					if (accept && next_cycles != `RAB_CYC_ONE)
					begin
						// hold off issue for the remaining cycles
						state <= rab_pkg::st_busy;
						wait_left <= next_cycles - 3'h2;
						issue_ready <= 1'b0;
					end
				end
				rab_pkg::st_busy:
				begin
					if (wait_left == 3'h0)
					begin
						state <= rab_pkg::st_ready;
						issue_ready <= 1'b1;
					end
					else
						wait_left <= wait_left - 3'h1;
				end
				default:
				begin
					state <= rab_pkg::st_ready;
					issue_ready <= 1'b1;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// program counter and status

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pc <= `RAB_PC_RESET;
			status_register <= `RAB_STATUS_REGISTER_RESET;
		end
		else if (accept)
		begin
			pc <= next_pc;
			status_register <= next_status_register;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register file and reports

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < 32; i++)
				gpr[i] <= `RAB_GPR_RESET;
		end
		else if (accept && next_wr.valid)
		begin
			gpr[next_wr.addr] <= next_wr.data[7:0];
			if (next_wr.word)
				gpr[next_wr.addr | 5'h01] <= next_wr.data[15:8];
		end
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			reg_wr <= '0;
			push <= '0;
		end
		else
		begin
			reg_wr <= accept ? next_wr : '0;
			push <= accept ? next_push : '0;
		end
	end

endmodule

// ---- sim/rab_exec_asserts.sv ----
// Purpose: timing and side-effect checks on the executor ports
// Assumes: bound to every rab_exec instance
// Notes: all effects land at the issue edge
`timescale 1ns/1ps

module rab_exec_checker
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// instruction side
	input wire rab_pkg::rab_instr_type instr,
	input wire logic issue_ready,
	// results
	input wire logic [15:0] pc,
	input wire logic [7:0] status_register,
	input wire rab_pkg::rab_wr_type reg_wr,
	input wire rab_pkg::rab_push_type push
);
	logic take;
	logic [15:0] rel_tgt;
	rab_pkg::rab_op_type op;
	assign take = instr.valid && issue_ready;
	assign op = instr.op;

	default clocking dcb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	// relative target of the instruction offered last cycle, registered at the edge
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			rel_tgt <= 16'h0000;
		else
			rel_tgt <= pc + {{4{instr.offset[11]}}, instr.offset} + 16'h0001;
	end

	////////////////////////////////////////////////////////////////
	a_alu_one_cycle: assert property (
		take && op inside {[rab_pkg::op_add : rab_pkg::op_sbc], rab_pkg::op_cp,
		[rab_pkg::op_and : rab_pkg::op_clear_bits_mask], rab_pkg::op_cpc} |=> issue_ready)
		else $error("single-cycle op stalled");
	a_word_two_cycle: assert property (
		take && op inside {[rab_pkg::op_word_add_immediate : rab_pkg::op_word_subtract_immediate]}
		|=> !issue_ready ##1 issue_ready) else $error("word op not two cycles");
	a_mul_two_cycle: assert property (
		take && op inside {[rab_pkg::op_mul : rab_pkg::op_fmulsu]}
		|=> !issue_ready ##1 issue_ready) else $error("multiply not two cycles");
	a_mul_prod_pair: assert property (
		take && op inside {[rab_pkg::op_mul : rab_pkg::op_fmulsu]}
		|=> reg_wr.valid && reg_wr.word && reg_wr.addr == 5'h00) else $error("product misplaced");
	a_call_four_cycle: assert property (
		take && op == rab_pkg::op_call |=> !issue_ready [*3] ##1 issue_ready)
		else $error("call not four cycles");
	a_relative_call_push: assert property (
		take && op == rab_pkg::op_relative_call |=> push.valid && push.addr == $past(pc) + 16'h0001)
		else $error("relative call return wrong");
	a_flow_keeps_flags: assert property (
		take && op inside {[rab_pkg::op_relative_jump : rab_pkg::op_compare_skip_equal],
		[rab_pkg::op_skip_reg_bit_clear : rab_pkg::op_branch_signed_lt]}
		|=> $stable(status_register)) else $error("flow op changed flags");
	a_cmp_no_write: assert property (
		take && op inside {rab_pkg::op_cp, rab_pkg::op_cpc} |=> !reg_wr.valid)
		else $error("compare wrote a register");
	a_logic_other_flags: assert property (
		take && op inside {[rab_pkg::op_and : rab_pkg::op_eor], rab_pkg::op_clear_bits_mask}
		|=> $stable(status_register[7:4]) && $stable(status_register[0]))
		else $error("logic op changed other flags");
	a_ge_taken: assert property (
		take && op == rab_pkg::op_branch_signed_ge && !(status_register[2] ^ status_register[3])
		|=> pc == rel_tgt && !issue_ready) else $error("signed ge branch wrong");
	a_lt_untaken: assert property (
		take && op == rab_pkg::op_branch_signed_lt && !(status_register[2] ^ status_register[3])
		|=> pc == $past(pc) + 16'h0001 && issue_ready) else $error("signed lt branch wrong");
	a_busy_pc_hold: assert property (
		!issue_ready |=> $stable(pc)) else $error("issue while busy");

	c_call: cover property (take && op == rab_pkg::op_call);
	c_mul: cover property (take && op == rab_pkg::op_fmulsu);
	c_skip: cover property (take && op == rab_pkg::op_skip_io_bit_set ##1 !issue_ready);
endmodule

bind rab_exec rab_exec_checker i_checker
(
	.ref_clk(ref_clk),
	.rstn(rstn),
	.instr(instr),
	.issue_ready(issue_ready),
	.pc(pc),
	.status_register(status_register),
	.reg_wr(reg_wr),
	.push(push)
);

// ---- sim/rab_fetch_model.sv ----
// Purpose: fetch-side source of decoded instructions
// Assumes: present is called at a falling edge of ref_clk
// Notes: returns at the falling edge after the take
`timescale 1ns/1ps

module rab_fetch_model
(
	// clock and handshake
	input wire logic ref_clk,
	input wire logic issue_ready,
	// instruction out
	output rab_pkg::rab_instr_type instr
);
	initial
	begin
		instr = '0;
	end

	// hold while refused, count refused edges
	task automatic present(input rab_pkg::rab_instr_type ins, output int waits);
		waits = 0;
		instr = ins;
		while (issue_ready !== 1'b1 && waits < 8)
		begin
			@(negedge ref_clk);
			waits++;
		end
		@(negedge ref_clk);
	endtask
endmodule

// ---- sim/tb_risc8_alu_branch_exec.sv ----
// Purpose: random instruction stream checked against a behavioural model
// Assumes: one 200 MHz clock, register file starts at zero
// Notes: each result checked at the falling edge after its take
`timescale 1ns/1ps

module tb_risc8_alu_branch_exec;
	logic ref_clk;
	logic rstn;
	rab_pkg::rab_instr_type instr;
	rab_pkg::rab_instr_type ins;
	logic issue_ready;
	logic [15:0] pc;
	logic [7:0] status_register;
	rab_pkg::rab_wr_type reg_wr;
	rab_pkg::rab_push_type push;
	int miscompares;
	int comparisons;
	int cycles;
	int seed;
	int waits;
	logic [95:0] rv;
	logic [7:0] rf [32];
	logic [15:0] m_pc;
	logic [7:0] m_sr;
	rab_pkg::rab_wr_type m_wr;
	rab_pkg::rab_push_type m_push;
	int m_cyc;

	rab_exec i_dut
	(
		.ref_clk(ref_clk),
		.rstn(rstn),
		.instr(instr),
		.issue_ready(issue_ready),
		.pc(pc),
		.status_register(status_register),
		.reg_wr(reg_wr),
		.push(push)
	);

	rab_fetch_model i_fetch
	(
		.ref_clk(ref_clk),
		.issue_ready(issue_ready),
		.instr(instr)
	);

	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic conclude();
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic wr(input logic [4:0] ad, input logic wd, input logic [15:0] d);
		m_wr = {1'b1, wd, ad, d};
		rf[ad] = d[7:0];
		if (wd)
			rf[ad | 5'h01] = d[15:8];
	endtask

	task automatic zn(input logic [7:0] v, input logic keep);
		m_sr[1] = (v == 8'h00) && (!keep || m_sr[1]);
		m_sr[2] = v[7];
	endtask

	////////////////////////////////////////////////////////////////
	task automatic model(input rab_pkg::rab_instr_type i);
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] v;
		logic [8:0] r;
		logic [4:0] h;
		logic [16:0] q;
		logic signed [17:0] p;
		logic [15:0] ret;
		logic [15:0] rel;
		logic s;
		logic c;
		logic hit;
		a = rf[i.rd];
		b = i.use_imm ? i.imm : rf[i.rr];
		ret = m_pc + 16'h0001 + 16'(i.two_word);
		rel = m_pc + {{4{i.offset[11]}}, i.offset} + 16'h0001;
		m_cyc = 1;
		m_wr = '0;
		m_push = '0;
		m_pc = ret;
		case (i.op) inside
			rab_pkg::op_add, rab_pkg::op_adc, rab_pkg::op_sub, rab_pkg::op_sbc, rab_pkg::op_cp,
			rab_pkg::op_cpc:
			begin
				s = !(i.op inside {rab_pkg::op_add, rab_pkg::op_adc});
				c = i.op inside {rab_pkg::op_adc, rab_pkg::op_sbc, rab_pkg::op_cpc} && m_sr[0];
				r = s ? 9'(a) - 9'(b) - 9'(c) : 9'(a) + 9'(b) + 9'(c);
				h = s ? 5'(a[3:0]) - 5'(b[3:0]) - 5'(c) : 5'(a[3:0]) + 5'(b[3:0]) + 5'(c);
				m_sr[0] = r[8];
				m_sr[5] = h[4];
				m_sr[3] = (a[7] ^ b[7] ^ !s) && (r[7] != a[7]);
				zn(r[7:0], i.op inside {rab_pkg::op_sbc, rab_pkg::op_cpc});
				if (!(i.op inside {rab_pkg::op_cp, rab_pkg::op_cpc}))
					wr(i.rd, 1'b0, {8'h00, r[7:0]});
			end
			[rab_pkg::op_and : rab_pkg::op_clear_bits_mask]:
			begin
				case (i.op)
					rab_pkg::op_and: v = a & b;
					rab_pkg::op_or: v = a | b;
					rab_pkg::op_eor: v = a ^ b;
					rab_pkg::op_clear_bits_mask: v = a & ~i.imm;
					default: v = ~a;
				endcase
				m_sr[0] = m_sr[0] | (i.op == rab_pkg::op_ones_complement);
				m_sr[3] = 1'b0;
				zn(v, 1'b0);
				wr(i.rd, 1'b0, {8'h00, v});
			end
			rab_pkg::op_word_add_immediate, rab_pkg::op_word_subtract_immediate:
			begin
				s = i.op == rab_pkg::op_word_subtract_immediate;
				v = rf[i.rd | 5'h01];
				q = {1'b0, v, a};
				q = s ? q - 17'(i.imm) : q + 17'(i.imm);
				m_sr[0] = q[16];
				m_sr[3] = (v[7] ^ q[15]) && (v[7] == s);
				m_sr[2] = q[15];
				m_sr[1] = q[15:0] == 16'h0000;
				m_sr[4] = q[15] ^ m_sr[3];
				wr(i.rd, 1'b1, q[15:0]);
				m_cyc = 2;
			end
			[rab_pkg::op_mul : rab_pkg::op_fmulsu]:
			begin
				s = i.op inside {rab_pkg::op_muls, rab_pkg::op_fmuls};
				c = !(i.op inside {rab_pkg::op_mul, rab_pkg::op_fractional_multiply});
				p = $signed({c & a[7], a}) * $signed({s & rf[i.rr][7], rf[i.rr]});
				m_sr[0] = p[15];
				if (i.op >= rab_pkg::op_fractional_multiply)
					p = p <<< 1;
				m_sr[1] = p[15:0] == 16'h0000;
				wr(5'h00, 1'b1, p[15:0]);
				m_cyc = 2;
			end
			[rab_pkg::op_relative_jump : rab_pkg::op_call]:
			begin
				hit = i.op inside {rab_pkg::op_relative_call, rab_pkg::op_indirect_call, rab_pkg::op_call};
				m_pc = i.op < rab_pkg::op_indirect_jump ? rel : i.op < rab_pkg::op_jmp ? {rf[31], rf[30]}
					: i.target;
				m_cyc = 2 + hit + (i.op >= rab_pkg::op_jmp);
				if (hit)
					m_push = {1'b1, ret};
			end
			[rab_pkg::op_compare_skip_equal : rab_pkg::op_branch_signed_lt]:
			begin
				v = i.op >= rab_pkg::op_skip_io_bit_clear ? i.io_value : rf[i.rr];
				hit = v[i.bit_sel] == (i.op inside {rab_pkg::op_skip_reg_bit_set, rab_pkg::op_skip_io_bit_set});
				if (i.op == rab_pkg::op_compare_skip_equal)
					hit = a == rf[i.rr];
				if (i.op >= rab_pkg::op_branch_status_bit_set)
					hit = m_sr[i.bit_sel] == (i.op == rab_pkg::op_branch_status_bit_set);
				if (i.op >= rab_pkg::op_branch_signed_ge)
					hit = (m_sr[2] ^ m_sr[3]) == (i.op == rab_pkg::op_branch_signed_lt);
				s = i.op >= rab_pkg::op_branch_status_bit_set;
				if (hit)
				begin
					m_pc = s ? rel : ret + 16'h0001 + 16'(i.next_two_word);
					m_cyc = 2 + int'(!s && i.next_two_word);
				end
			end
			default: ;
		endcase
	endtask

	////////////////////////////////////////////////////////////////
	initial
	begin
		seed = 32'h117603d1;
		rstn = 1'b0;
		m_pc = 16'h0000;
		m_sr = 8'h00;
		m_cyc = 1;
		for (int k = 0; k < 32; k++)
			rf[k] = 8'h00;
		repeat (10) @(negedge ref_clk);
		cmp_val(32'({issue_ready, pc, status_register}), 32'h01000000);
		$display("test reset done");
		rstn = 1'b1;
		for (int k = 0; k < 2500; k++)
		begin
			rv = {$random(seed), $random(seed), $random(seed)};
			ins = rv[66:0];
			ins.valid = 1'b1;
			ins.op = rab_pkg::rab_op_type'(1 + {$random(seed)} % 34);
			ins.bit_sel = ins.bit_sel % 3'h7;
			ins.two_word = ins.op inside {rab_pkg::op_jmp, rab_pkg::op_call};
			ins.use_imm &= ins.op inside {rab_pkg::op_sub, rab_pkg::op_sbc, rab_pkg::op_and,
				rab_pkg::op_or, rab_pkg::op_cp, [rab_pkg::op_mul : rab_pkg::op_fmulsu],
				rab_pkg::op_compare_skip_equal, rab_pkg::op_skip_reg_bit_clear, rab_pkg::op_skip_reg_bit_set};
			ins.use_imm |= ins.op == rab_pkg::op_clear_bits_mask;
			if (ins.op inside {rab_pkg::op_word_add_immediate, rab_pkg::op_word_subtract_immediate})
				ins.rd[0] = 1'b0;
			i_fetch.present(ins, waits);
			cmp_val(waits, m_cyc - 1);
			model(ins);
			cmp_val(pc, m_pc);
			cmp_val(status_register, m_sr);
			cmp_val(reg_wr.valid, m_wr.valid);
			if (m_wr.valid)
				cmp_val(32'(reg_wr), 32'(m_wr));
			cmp_val(push.valid, m_push.valid);
			if (m_push.valid)
				cmp_val(32'(push), 32'(m_push));
		end
		$display("test random stream done");
		conclude();
	end
endmodule
